// ### gpx_pkg.sv
// Shared constants, register map and carrier types of the GPIO expander core.
`default_nettype none
package gpx_pkg;
   localparam int GPX_PINS = 16;
   localparam int GPX_AW = 6;
   localparam int GPX_DW = 8;
   localparam int GPX_CNT_W = 7;

   localparam logic [GPX_AW-1:0] GPX_A_STATE_LO = 6'h00;
   localparam logic [GPX_AW-1:0] GPX_A_STATE_HI = 6'h01;
   localparam logic [GPX_AW-1:0] GPX_A_OUT_LO = 6'h02;
   localparam logic [GPX_AW-1:0] GPX_A_OUT_HI = 6'h03;
   localparam logic [GPX_AW-1:0] GPX_A_INV_LO = 6'h04;
   localparam logic [GPX_AW-1:0] GPX_A_INV_HI = 6'h05;
   localparam logic [GPX_AW-1:0] GPX_A_DIR_LO = 6'h06;
   localparam logic [GPX_AW-1:0] GPX_A_DIR_HI = 6'h07;
   localparam logic [GPX_AW-1:0] GPX_A_PUP_LO = 6'h08;
   localparam logic [GPX_AW-1:0] GPX_A_PUP_HI = 6'h09;
   localparam logic [GPX_AW-1:0] GPX_A_IEN_LO = 6'h0a;
   localparam logic [GPX_AW-1:0] GPX_A_IEN_HI = 6'h0b;
   localparam logic [GPX_AW-1:0] GPX_A_FLT_LO = 6'h0c;
   localparam logic [GPX_AW-1:0] GPX_A_FLT_HI = 6'h0d;
   localparam logic [GPX_AW-1:0] GPX_A_PEND_LO = 6'h0e;
   localparam logic [GPX_AW-1:0] GPX_A_PEND_HI = 6'h0f;
   localparam logic [GPX_AW-1:0] GPX_A_RISE_LO = 6'h10;
   localparam logic [GPX_AW-1:0] GPX_A_RISE_HI = 6'h11;
   localparam logic [GPX_AW-1:0] GPX_A_FALL_LO = 6'h12;
   localparam logic [GPX_AW-1:0] GPX_A_FALL_HI = 6'h13;
   localparam logic [GPX_AW-1:0] GPX_A_GLF_LO = 6'h14;
   localparam logic [GPX_AW-1:0] GPX_A_GLF_HI = 6'h15;

   localparam logic [GPX_PINS-1:0] GPX_RST_ONES = 16'hffff;
   localparam logic [GPX_PINS-1:0] GPX_RST_ZERO = 16'h0000;
   localparam logic [GPX_PINS-1:0] GPX_MASK_LO = 16'h00ff;
   localparam logic [GPX_PINS-1:0] GPX_MASK_HI = 16'hff00;
   localparam logic [GPX_DW-1:0] GPX_BYTE_ZERO = 8'h00;

   localparam int GPX_CLK_NS = 20;
   localparam int GPX_HOLD_NS = 1075;
   localparam int GPX_REJECT_NS = 225;
   localparam int GPX_HOLD_CYC = (GPX_HOLD_NS + GPX_CLK_NS - 1) / GPX_CLK_NS;
   localparam int GPX_REJECT_CYC = (GPX_REJECT_NS + GPX_CLK_NS - 1) / GPX_CLK_NS;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [GPX_AW-1:0] addr;
      logic [GPX_DW-1:0] wdata;
   } gpx_bus_t;

   typedef struct packed {
      logic [GPX_PINS-1:0] output_level_bits;
      logic [GPX_PINS-1:0] input_invert_bits;
      logic [GPX_PINS-1:0] pin_direction_bits;
      logic [GPX_PINS-1:0] pull_up_bits;
      logic [GPX_PINS-1:0] pin_irq_enable_bits;
      logic [GPX_PINS-1:0] output_float_bits;
      logic [GPX_PINS-1:0] rise_edge_select_bits;
      logic [GPX_PINS-1:0] fall_edge_select_bits;
      logic [GPX_PINS-1:0] glitch_filter_enable_bits;
   } gpx_cfg_t;
endpackage
`default_nettype wire

// ### gpx_core.sv
// Pin direction, output drive, input view and edge interrupt logic of the GPIO expander.
//
// How it works
// - Disabled input pins never raise an interrupt.
// - Output pins never raise an interrupt.
// - Both selects equal, no filter: either edge.
// - Both selects equal, filter: edge held long.
// - Rise select, no filter: rising edges only.
// - Rise select, filter: rise held long.
// - Fall select, no filter: falling edges only.
// - Fall select, filter: fall held long.
// - Pin-state read clears that bank's pending.
// - Both selects clear: revert to captured level clears.
// - Pin-state shows input level, optionally inverted.
// - Output pins show stored output level.
// - Writes to pin-state are ignored.
// - Low bank pins 7..0, high 15..8.
// - Output level register drives, reads back stored.
// - Invert bit one complements an input pin's view.
// - Direction resets input; zero means output.
// - Read/write and six address bits select register.
// - Float bit tristates output, keeps level.
// - Filter rejects short pulses, resets enabled.
// - Interrupt enable one enables; resets disabled.
`timescale 1ns/1ps
`default_nettype none
module gpx_core #(
   parameter int HOLD_CYC = gpx_pkg::GPX_HOLD_CYC
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire gpx_pkg::gpx_bus_t bus_in,
   output logic [gpx_pkg::GPX_DW-1:0] rd_data_out,
   input wire logic [gpx_pkg::GPX_PINS-1:0] pin_in,
   output logic [gpx_pkg::GPX_PINS-1:0] pin_out,
   output logic [gpx_pkg::GPX_PINS-1:0] pin_oe_out,
   output logic [gpx_pkg::GPX_PINS-1:0] pull_up_en_out,
   output logic irq_out,
   output logic irq_oe_out
);
   import gpx_pkg::*;

   localparam logic [GPX_CNT_W-1:0] HOLD_CNT = GPX_CNT_W'(HOLD_CYC);
   localparam logic [GPX_CNT_W-1:0] CNT_ONE = 7'h01;
   localparam logic [GPX_CNT_W-1:0] CNT_ZERO = 7'h00;

   gpx_cfg_t cfg;
   logic [GPX_PINS-1:0] meta;
   logic [GPX_PINS-1:0] sync;
   logic [GPX_PINS-1:0] sync_d;
   logic [GPX_PINS-1:0] qlvl;
   logic [GPX_PINS-1:0] det;
   logic [GPX_PINS-1:0] det_d;
   logic [GPX_PINS-1:0] cap;
   logic [GPX_PINS-1:0] pend;
   logic [GPX_PINS-1:0] next_pend;
   logic [GPX_PINS-1:0] ev_set;
   logic [GPX_PINS-1:0] ev_clr;
   logic [GPX_PINS-1:0] view;
   logic [GPX_PINS-1:0] edge_seen;
   logic [GPX_PINS-1:0] rd_mask;
   logic [GPX_CNT_W-1:0] stab_cnt [GPX_PINS];
   logic [GPX_DW-1:0] next_rd_data;
   logic rd_lo;
   logic rd_hi;

   // Byte lanes map bit 7..0 onto pins 7..0 or 15..8.
   function automatic logic [GPX_PINS-1:0] put_byte(input logic [GPX_PINS-1:0] old, input logic hi,
                                                     input logic [GPX_DW-1:0] d);
      logic [GPX_PINS-1:0] r;
      r = old;
      if (hi)
      begin
         r[GPX_PINS-1:GPX_DW] = d;
      end
      else
      begin
         r[GPX_DW-1:0] = d;
      end
      return r;
   endfunction

   function automatic logic [GPX_DW-1:0] get_byte(input logic [GPX_PINS-1:0] v, input logic hi);
      return hi ? v[GPX_PINS-1:GPX_DW] : v[GPX_DW-1:0];
   endfunction

   // Two stages keep metastability away from the detectors.
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
      begin
         meta <= GPX_RST_ZERO;
         sync <= GPX_RST_ZERO;
         sync_d <= GPX_RST_ZERO;
      end
      else
      begin
         meta <= pin_in;
         sync <= meta;
         sync_d <= sync;
      end
   end

   assign rd_lo = bus_in.rd && (bus_in.addr == GPX_A_STATE_LO);
   assign rd_hi = bus_in.rd && (bus_in.addr == GPX_A_STATE_HI);

   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
      begin
         cfg.output_level_bits <= GPX_RST_ONES;
         cfg.input_invert_bits <= GPX_RST_ZERO;
         cfg.pin_direction_bits <= GPX_RST_ONES;
         cfg.pull_up_bits <= GPX_RST_ZERO;
         cfg.pin_irq_enable_bits <= GPX_RST_ZERO;
         cfg.output_float_bits <= GPX_RST_ZERO;
         cfg.rise_edge_select_bits <= GPX_RST_ZERO;
         cfg.fall_edge_select_bits <= GPX_RST_ZERO;
         cfg.glitch_filter_enable_bits <= GPX_RST_ONES;
      end
      else if (bus_in.wr)
      begin
         case (bus_in.addr)
            GPX_A_OUT_LO, GPX_A_OUT_HI:
               cfg.output_level_bits <= put_byte(cfg.output_level_bits, bus_in.addr[0], bus_in.wdata);
            GPX_A_INV_LO, GPX_A_INV_HI:
               cfg.input_invert_bits <= put_byte(cfg.input_invert_bits, bus_in.addr[0], bus_in.wdata);
            GPX_A_DIR_LO, GPX_A_DIR_HI:
               cfg.pin_direction_bits <= put_byte(cfg.pin_direction_bits, bus_in.addr[0], bus_in.wdata);
            GPX_A_PUP_LO, GPX_A_PUP_HI:
               cfg.pull_up_bits <= put_byte(cfg.pull_up_bits, bus_in.addr[0], bus_in.wdata);
            GPX_A_IEN_LO, GPX_A_IEN_HI:
               cfg.pin_irq_enable_bits <= put_byte(cfg.pin_irq_enable_bits, bus_in.addr[0], bus_in.wdata);
            GPX_A_FLT_LO, GPX_A_FLT_HI:
               cfg.output_float_bits <= put_byte(cfg.output_float_bits, bus_in.addr[0], bus_in.wdata);
            GPX_A_RISE_LO, GPX_A_RISE_HI:
               cfg.rise_edge_select_bits <= put_byte(cfg.rise_edge_select_bits, bus_in.addr[0], bus_in.wdata);
            GPX_A_FALL_LO, GPX_A_FALL_HI:
               cfg.fall_edge_select_bits <= put_byte(cfg.fall_edge_select_bits, bus_in.addr[0], bus_in.wdata);
            GPX_A_GLF_LO, GPX_A_GLF_HI:
               cfg.glitch_filter_enable_bits <= put_byte(cfg.glitch_filter_enable_bits, bus_in.addr[0],
                                                         bus_in.wdata);
            default:
               cfg <= cfg;
         endcase
      end
   end

   // Input view, outputs read stored level.
   assign view = (cfg.pin_direction_bits & (sync ^ cfg.input_invert_bits)) |
                 (~cfg.pin_direction_bits & cfg.output_level_bits);

   always_comb
   begin
      next_rd_data = GPX_BYTE_ZERO;
      if (bus_in.rd)
      begin
         // Bank selection by address bit zero.
         case (bus_in.addr)
            GPX_A_STATE_LO, GPX_A_STATE_HI: next_rd_data = get_byte(view, bus_in.addr[0]);
            GPX_A_OUT_LO, GPX_A_OUT_HI: next_rd_data = get_byte(cfg.output_level_bits, bus_in.addr[0]);
            GPX_A_INV_LO, GPX_A_INV_HI: next_rd_data = get_byte(cfg.input_invert_bits, bus_in.addr[0]);
            GPX_A_DIR_LO, GPX_A_DIR_HI: next_rd_data = get_byte(cfg.pin_direction_bits, bus_in.addr[0]);
            GPX_A_PUP_LO, GPX_A_PUP_HI: next_rd_data = get_byte(cfg.pull_up_bits, bus_in.addr[0]);
            GPX_A_IEN_LO, GPX_A_IEN_HI: next_rd_data = get_byte(cfg.pin_irq_enable_bits, bus_in.addr[0]);
            GPX_A_FLT_LO, GPX_A_FLT_HI: next_rd_data = get_byte(cfg.output_float_bits, bus_in.addr[0]);
            GPX_A_PEND_LO, GPX_A_PEND_HI: next_rd_data = get_byte(pend, bus_in.addr[0]);
            GPX_A_RISE_LO, GPX_A_RISE_HI: next_rd_data = get_byte(cfg.rise_edge_select_bits, bus_in.addr[0]);
            GPX_A_FALL_LO, GPX_A_FALL_HI: next_rd_data = get_byte(cfg.fall_edge_select_bits, bus_in.addr[0]);
            GPX_A_GLF_LO, GPX_A_GLF_HI: next_rd_data = get_byte(cfg.glitch_filter_enable_bits, bus_in.addr[0]);
            default: next_rd_data = GPX_BYTE_ZERO;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
      begin
         rd_data_out <= GPX_BYTE_ZERO;
      end
      else
      begin
         rd_data_out <= next_rd_data;
      end
   end

   // Level qualifies only after a stable hold.
   // The hold far exceeds the reject time, so short pulses never reach the detector.
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
      begin
         qlvl <= GPX_RST_ZERO;
         for (int i = 0; i < GPX_PINS; i++)
         begin
            stab_cnt[i] <= CNT_ZERO;
         end
      end
      else
      begin
         for (int i = 0; i < GPX_PINS; i++)
         begin
            if (sync[i] != sync_d[i])
            begin
               stab_cnt[i] <= CNT_ZERO;
            end
            else if (stab_cnt[i] != HOLD_CNT)
            begin
               stab_cnt[i] <= stab_cnt[i] + CNT_ONE;
            end
            else
            begin
               qlvl[i] <= sync[i];
            end
         end
      end
   end

   assign det = (cfg.glitch_filter_enable_bits & qlvl) | (~cfg.glitch_filter_enable_bits & sync);
   assign edge_seen = det ^ det_d;

   assign ev_set = cfg.pin_direction_bits & cfg.pin_irq_enable_bits & edge_seen &
                   (~(cfg.rise_edge_select_bits ^ cfg.fall_edge_select_bits) |
                    (cfg.rise_edge_select_bits & det) | (cfg.fall_edge_select_bits & ~det));

   assign rd_mask = (rd_lo ? GPX_MASK_LO : GPX_RST_ZERO) | (rd_hi ? GPX_MASK_HI : GPX_RST_ZERO);
   assign ev_clr = rd_mask | (~cfg.rise_edge_select_bits & ~cfg.fall_edge_select_bits & ~(det ^ cap));
   // A new event beats a clear in the same cycle.
   assign next_pend = (pend & ~ev_clr) | ev_set;

   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
      begin
         det_d <= GPX_RST_ZERO;
         cap <= GPX_RST_ZERO;
         pend <= GPX_RST_ZERO;
      end
      else
      begin
         det_d <= det;
         cap <= (rd_mask & det) | (~rd_mask & cap);
         pend <= next_pend;
      end
   end

   // Float or input releases the pin.
   assign pin_oe_out = ~cfg.pin_direction_bits & ~cfg.output_float_bits;
   assign pin_out = cfg.output_level_bits;
   assign pull_up_en_out = cfg.pull_up_bits;
   assign irq_out = 1'b0;
   assign irq_oe_out = |pend;

   // One high-bank pin is watched; a per-pin loop would multiply the property count.
   localparam int AP = 11;
   logic [GPX_CNT_W-1:0] hcnt;
   always_ff @(posedge sys_clk_in)
   begin
      if (!rst_n_in)
      begin
         hcnt <= CNT_ZERO;
      end
      else if (sync[AP] != sync_d[AP])
      begin
         hcnt <= CNT_ZERO;
      end
      else if (hcnt != {GPX_CNT_W{1'b1}})
      begin
         hcnt <= hcnt + CNT_ONE;
      end
   end

   sequence s_fast_cfg;
      cfg.pin_direction_bits[AP] && cfg.pin_irq_enable_bits[AP] && !cfg.glitch_filter_enable_bits[AP] &&
      !$past(cfg.glitch_filter_enable_bits[AP]) && !pend[AP] && !rd_hi;
   endsequence

   sequence s_rise_only;
      cfg.rise_edge_select_bits[AP] && !cfg.fall_edge_select_bits[AP];
   endsequence

   sequence s_fall_only;
      !cfg.rise_edge_select_bits[AP] && cfg.fall_edge_select_bits[AP];
   endsequence

   AST_NO_IRQ_DISABLED: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(pend[AP]) |-> $past(cfg.pin_irq_enable_bits[AP]))
      else $error("Pending set on a pin with interrupts disabled.");

   AST_NO_IRQ_OUTPUT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      ((pend & ~$past(pend)) & ~$past(cfg.pin_direction_bits)) == GPX_RST_ZERO)
      else $error("Pending set on an output pin.");

   AST_EITHER_EDGE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (s_fast_cfg and (!cfg.rise_edge_select_bits[AP] && !cfg.fall_edge_select_bits[AP] &&
       $changed(sync[AP]))) |=> pend[AP])
      else $error("Unfiltered edge did not set pending.");

   AST_FILTER_HOLD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      ($rose(pend[AP]) && $past(cfg.glitch_filter_enable_bits[AP]) &&
       $past(cfg.glitch_filter_enable_bits[AP], 2)) |-> ($past(hcnt) >= HOLD_CNT))
      else $error("Filtered interrupt before the hold time.");

   AST_RISE_IGNORES_FALL: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (s_fast_cfg and s_rise_only and $fell(sync[AP])) |=> !pend[AP])
      else $error("Falling edge set pending in rise mode.");

   AST_FALL_IGNORES_RISE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (s_fast_cfg and s_fall_only and $rose(sync[AP])) |=> !pend[AP])
      else $error("Rising edge set pending in fall mode.");

   AST_READ_CLEARS: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (rd_hi && (ev_set & GPX_MASK_HI) == GPX_RST_ZERO) |=> ((pend & GPX_MASK_HI) == GPX_RST_ZERO))
      else $error("Pin-state read left high bank pending.");

   AST_VIEW_DATA: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      rd_hi |=> (rd_data_out == $past(view[GPX_PINS-1:GPX_DW])))
      else $error("Pin-state read returned the wrong byte.");

   AST_STATE_WRITE_IGNORED: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (bus_in.wr && (bus_in.addr == GPX_A_STATE_LO || bus_in.addr == GPX_A_STATE_HI)) |=> (cfg == $past(cfg)))
      else $error("Write to pin-state changed configuration.");

   AST_FLOAT_RELEASE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      cfg.output_float_bits[AP] |-> (!pin_oe_out[AP] && pin_out[AP] == cfg.output_level_bits[AP]))
      else $error("Floated pin still driven.");

   AST_IRQ_PIN: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $fell(|pend) |-> !irq_oe_out ##1 (irq_oe_out == (|pend)))
      else $error("Interrupt pin does not follow pending.");

   AST_FILTERED_DIRECTION: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      ($rose(pend[AP]) && $past(cfg.glitch_filter_enable_bits[AP]) &&
       $past(cfg.glitch_filter_enable_bits[AP], 2) &&
       ($past(cfg.rise_edge_select_bits[AP]) != $past(cfg.fall_edge_select_bits[AP]))) |->
      ($past(qlvl[AP]) == $past(cfg.rise_edge_select_bits[AP])))
      else $error("Filtered interrupt raised on the unselected edge.");

   AST_REVERT_CLEARS: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (pend[AP] && !cfg.rise_edge_select_bits[AP] && !cfg.fall_edge_select_bits[AP] &&
       (det[AP] == cap[AP]) && !ev_set[AP]) |=> !pend[AP])
      else $error("Pending survived a return to the captured level.");

   AST_OUTPUT_VIEW: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (rd_hi && !cfg.pin_direction_bits[AP]) |=>
      (rd_data_out[AP - GPX_DW] == $past(cfg.output_level_bits[AP])))
      else $error("Output pin read did not return its stored level.");

   AST_INVERT_VIEW: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (rd_hi && cfg.pin_direction_bits[AP]) |=>
      (rd_data_out[AP - GPX_DW] == $past(sync[AP] ^ cfg.input_invert_bits[AP])))
      else $error("Input pin read ignored its inversion bit.");

   AST_OUTPUT_DRIVES: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (!cfg.pin_direction_bits[AP] && !cfg.output_float_bits[AP]) |-> pin_oe_out[AP])
      else $error("Output pin not driven.");
endmodule
`default_nettype wire

// ### gpx_pin_dev.sv
// Behavioural model of the external devices wired to the expander's pins.
`timescale 1ns/1ps
`default_nettype none
module gpx_pin_dev (
   input wire logic sys_clk_in,
   input wire logic [gpx_pkg::GPX_PINS-1:0] ext_lvl_in,
   input wire logic [gpx_pkg::GPX_PINS-1:0] ext_en_in,
   input wire logic [gpx_pkg::GPX_PINS-1:0] pin_drv_in,
   input wire logic [gpx_pkg::GPX_PINS-1:0] pin_oe_in,
   input wire logic [gpx_pkg::GPX_PINS-1:0] pull_up_in,
   output logic [gpx_pkg::GPX_PINS-1:0] pin_lvl_out
);
   import gpx_pkg::*;
   logic [GPX_PINS-1:0] float_lvl = 16'h5a5a;

   // A floating wire wanders every cycle, so a stale level never passes for a drive.
   always @(posedge sys_clk_in)
   begin
      float_lvl <= ~float_lvl;
   end

   assign pin_lvl_out = (pin_oe_in & pin_drv_in) | (~pin_oe_in & ext_en_in & ext_lvl_in)
      | (~pin_oe_in & ~ext_en_in & (pull_up_in | float_lvl));
endmodule
`default_nettype wire

// ### gpx_tb.sv
// Self-checking testbench of the GPIO expander core against a reference model.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import gpx_pkg::*;
   localparam int HOLD = 8;
   logic sys_clk_in;
   logic rst_n_in;
   gpx_bus_t bus;
   logic [GPX_DW-1:0] rd_data;
   logic [GPX_PINS-1:0] pin_lvl, pin_drv, pin_oe, pull_up, ext_lvl, ext_en;
   logic irq, irq_oe;
   logic [7:0] got;
   logic [2:0] mb;
   int n_errors = 0;
   int check_count = 0;
   int mdl [0:21];
   int rst_tab [0:21] = '{0, 0, 'hff, 'hff, 0, 0, 'hff, 'hff, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 'hff, 'hff};

   gpx_core #(.HOLD_CYC(HOLD)) dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .bus_in(bus),
      .rd_data_out(rd_data), .pin_in(pin_lvl), .pin_out(pin_drv), .pin_oe_out(pin_oe),
      .pull_up_en_out(pull_up), .irq_out(irq), .irq_oe_out(irq_oe));
   gpx_pin_dev pins (.sys_clk_in(sys_clk_in), .ext_lvl_in(ext_lvl), .ext_en_in(ext_en),
      .pin_drv_in(pin_drv), .pin_oe_in(pin_oe), .pull_up_in(pull_up), .pin_lvl_out(pin_lvl));

   initial
   begin
      sys_clk_in = 1'b0;
      forever #10 sys_clk_in = ~sys_clk_in;
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk_in);
      bus <= '0;
      if (a > 6'h01 && a < 6'h16 && a != GPX_A_PEND_LO && a != GPX_A_PEND_HI)
         mdl[a] = d;
   endtask

   task automatic reg_rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge sys_clk_in);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: GPX_BYTE_ZERO};
      @(posedge sys_clk_in);
      bus <= '0;
      #1;
      d = rd_data;
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp, input string name);
      reg_rd(a, got);
      chk(name, {8'h00, got}, {8'h00, exp});
   endtask

   function automatic logic [15:0] w16(input int lo);
      return 16'(mdl[lo] | (mdl[lo + 1] << 8));
   endfunction

   function automatic logic [7:0] view(input logic hi);
      logic [15:0] lvl;
      logic [15:0] v;
      lvl = (ext_en & ext_lvl) | (~ext_en & w16(8));
      v = (w16(6) & (lvl ^ w16(4))) | (~w16(6) & w16(2));
      return hi ? v[15:8] : v[7:0];
   endfunction

   // Moves pin 11, then checks the interrupt, its status bit and the clearing read.
   task automatic step(input logic lvl, input logic exp, input int wt);
      @(posedge sys_clk_in);
      ext_lvl[11] <= lvl;
      repeat (wt) @(posedge sys_clk_in);
      #1;
      chk("edge irq", {15'h0, irq_oe}, {15'h0, exp});
      rd_chk(GPX_A_PEND_HI, {4'h0, exp, 3'h0}, "pending hi");
      rd_chk(GPX_A_STATE_HI, view(1'b1), "state hi");
      chk("irq cleared", {15'h0, irq_oe}, 16'h0000);
   endtask

   initial
   begin
      #200000;
      n_errors++;
      end_sim();
   end

   initial
   begin
      bus = '0;
      rst_n_in = 1'b0;
      ext_lvl = 16'h0000;
      ext_en = 16'hffff;
      void'($urandom(32'h3b1f5396));
      for (int a = 0; a < 22; a++)
         mdl[a] = rst_tab[a];
      repeat (10) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      reg_wr(GPX_A_STATE_LO, 8'hff);
      reg_wr(GPX_A_STATE_HI, 8'hff);
      reg_wr(GPX_A_PEND_LO, 8'hff);
      reg_wr(GPX_A_PEND_HI, 8'hff);
      for (int a = 0; a < 22; a++)
         rd_chk(6'(a), 8'(mdl[a]), "reset value");
      rd_chk(6'h20, 8'h00, "unmapped read");
      chk("oe reset", pin_oe, 16'h0000);
      chk("irq idle", {15'h0, irq_oe}, 16'h0000);
      // Random read-back of every writable register.
      for (int a = 2; a < 22; a++)
      begin
         if (a != 14 && a != 15)
         begin
            reg_wr(6'(a), 8'($urandom));
            rd_chk(6'(a), 8'(mdl[a]), "read back");
         end
      end
      reg_wr(GPX_A_IEN_LO, 8'h00);
      reg_wr(GPX_A_IEN_HI, 8'h00);
      repeat (HOLD + 8) @(posedge sys_clk_in);
      reg_rd(GPX_A_STATE_LO, got);
      reg_rd(GPX_A_STATE_HI, got);
      // The second pass leaves pin 15 undriven so only its pull-up sets the level.
      for (int k = 0; k < 2; k++)
      begin
         if (k == 1)
            reg_wr(GPX_A_PUP_HI, 8'h80);
         @(posedge sys_clk_in);
         ext_lvl <= 16'($urandom);
         ext_en <= (k == 1) ? 16'h7fff : 16'hffff;
         repeat (4) @(posedge sys_clk_in);
         rd_chk(GPX_A_STATE_LO, view(1'b0), "state lo");
         rd_chk(GPX_A_STATE_HI, view(1'b1), "state hi");
         chk("pin drive", pin_drv, w16(2));
         chk("pin enable", pin_oe, ~w16(6) & ~w16(12));
         chk("pull-up", pull_up, w16(8));
      end
      @(posedge sys_clk_in);
      ext_lvl <= 16'h0000;
      ext_en <= 16'hffff;
      for (int a = 4; a < 14; a++)
         reg_wr(6'(a), (a == 6 || a == 7) ? 8'hff : 8'h00);
      // Every edge select and filter combination on pin 11.
      for (int m = 0; m < 8; m++)
      begin
         mb = 3'(m);
         reg_wr(GPX_A_RISE_HI, {4'h0, mb[0], 3'h0});
         reg_wr(GPX_A_FALL_HI, {4'h0, mb[1], 3'h0});
         reg_wr(GPX_A_GLF_HI, {4'h0, mb[2], 3'h0});
         reg_wr(GPX_A_IEN_HI, 8'h08);
         repeat (HOLD + 8) @(posedge sys_clk_in);
         reg_rd(GPX_A_STATE_HI, got);
         if (mb[2])
         begin
            @(posedge sys_clk_in);
            ext_lvl[11] <= 1'b1;
            repeat (3) @(posedge sys_clk_in);
            ext_lvl[11] <= 1'b0;
            repeat (HOLD + 8) @(posedge sys_clk_in);
            chk("glitch irq", {15'h0, irq_oe}, 16'h0000);
         end
         step(1'b1, (mb[0] == mb[1]) || mb[0], mb[2] ? HOLD + 8 : 6);
         step(1'b0, (mb[0] == mb[1]) || mb[1], mb[2] ? HOLD + 8 : 6);
      end
      reg_wr(GPX_A_RISE_HI, 8'h00);
      reg_wr(GPX_A_FALL_HI, 8'h00);
      reg_wr(GPX_A_GLF_HI, 8'h00);
      repeat (6) @(posedge sys_clk_in);
      reg_rd(GPX_A_STATE_HI, got);
      @(posedge sys_clk_in);
      ext_lvl[11] <= 1'b1;
      repeat (6) @(posedge sys_clk_in);
      chk("revert set", {15'h0, irq_oe}, 16'h0001);
      ext_lvl[11] <= 1'b0;
      repeat (6) @(posedge sys_clk_in);
      chk("revert clear", {15'h0, irq_oe}, 16'h0000);
      // Disabled input first, then a floated output pin moved from outside.
      for (int k = 0; k < 2; k++)
      begin
         reg_wr(GPX_A_IEN_HI, k ? 8'h08 : 8'h00);
         reg_wr(GPX_A_DIR_HI, k ? 8'hf7 : 8'hff);
         reg_wr(GPX_A_FLT_HI, k ? 8'h08 : 8'h00);
         @(posedge sys_clk_in);
         ext_lvl[11] <= 1'b1;
         repeat (6) @(posedge sys_clk_in);
         chk("quiet rise", {15'h0, irq_oe}, 16'h0000);
         rd_chk(GPX_A_STATE_HI, view(1'b1), "state hi");
         chk("float oe", pin_oe, ~w16(6) & ~w16(12));
         ext_lvl[11] <= 1'b0;
         repeat (6) @(posedge sys_clk_in);
         chk("quiet fall", {15'h0, irq_oe}, 16'h0000);
      end
      chk("irq level", {15'h0, irq}, 16'h0000);
      end_sim();
   end
endmodule
`default_nettype wire
